// ===== rtl/swdt_defines.svh
// Purpose: constants shared by both ends of the watchdog configuration link
// Assumes: 100 MHz mclk
// Notes:   port and register offsets, keys, the device register reset value and the device timing counts live here
`ifndef SWDT_DEFINES_SVH
`define SWDT_DEFINES_SVH

// ------------------------------------------------------------
// i/o port map and keys
// ------------------------------------------------------------
`define SWDT_INDEX_PORT   16'h03F0
`define SWDT_DATA_PORT    16'h03F1
`define SWDT_KEY_UNLOCK   8'h87
`define SWDT_KEY_EXIT     8'hAA

// ------------------------------------------------------------
// configuration registers
// ------------------------------------------------------------
`define SWDT_REG_LDEV     8'h07
`define SWDT_REG_ACT      8'h30
`define SWDT_REG_TMO      8'hF2
`define SWDT_LDEV_ACT     8'h07
`define SWDT_LDEV_TMO     8'h08
`define SWDT_ACT_ON       8'h01
`define SWDT_RD_UNDEF     8'hFF
`define SWDT_RD_UNMAPPED  8'h00
`define SWDT_RESET_VAL    8'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SWDT_CLK_NS       10
`define SWDT_SEC_NS       1000000000
`define SWDT_FIRST_SEC    6'd32
`define SWDT_MIN_SEC      6'd60
`define SWDT_RST_CYC      6'd32

// ------------------------------------------------------------
// controller register map (avalon byte addresses)
// ------------------------------------------------------------
`define SWDT_A_LDEV       5'h00
`define SWDT_A_REGNUM     5'h04
`define SWDT_A_DATA       5'h08
`define SWDT_A_CTRL       5'h0C
`define SWDT_A_STATUS     5'h10
`define SWDT_A_INT_STAT   5'h14
`define SWDT_A_INT_MASK   5'h18
`define SWDT_CTRL_GO      0
`define SWDT_CTRL_READ    1
`define SWDT_EV_DONE      0
`define SWDT_EV_WDRST     1

`endif

// ===== rtl/swdt_dev.sv
// Purpose: watchdog device behind an index/data configuration port pair
// Assumes: io strobes come from logic on mclk, so no synchronisers
// Notes:   second tick prescaler is a parameter so benches can shorten it
//
// Functional notes
// - two unlock keys in a row enter configuration
// - exit key leaves configuration, accesses ignored
// - index port 3F0h, data port 3F1h
// - host unlocks, selects, indexes, accesses, exits
// - index 07h then data latches logical device
// - index then data accesses selected device register
// - device 7 register 30h activates timer
// - device 8 register F2h holds count, 00h disables
// - count N expires after N-1 minutes plus 32s
// - eight-bit counter stepping once per minute
// - expiry of active enabled counter asserts reset
// - optional interrupt instead of reset

`include "swdt_defines.svh"

module swdt_dev #(
  parameter int SEC_CYCLES = `SWDT_SEC_NS / `SWDT_CLK_NS
) (
  // clock, reset, enable
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  // link to controller
  swdt_if.dev       bus,
  // user side
  input  wire logic irq_sel,
  output logic      wdt_sys_reset,
  output logic      wdt_irq,
  output logic      wdt_running
);
  import swdt_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic       cfg_r;
  logic       key1_r;
  swdt_byte_t index_r;
  swdt_byte_t ldev_r;
  swdt_byte_t act_r;
  swdt_byte_t tmo_r;
  swdt_byte_t min_r;
  logic [5:0] sec_r;
  logic [31:0] pre_r;
  logic       armed_r;
  logic       run_r;
  logic [5:0] rst_cnt_r;
  logic       irq_r;
  swdt_byte_t rdata_r;
  logic       rack_r;

  // ------------------------------------------------------------
  // port decode
  // ------------------------------------------------------------
  // index writes carry keys and register numbers
  wire idx_wr  = bus.io_wr && (bus.io_addr == `SWDT_INDEX_PORT);
  wire dat_wr  = bus.io_wr && (bus.io_addr == `SWDT_DATA_PORT);
  wire dat_rd  = bus.io_rd && (bus.io_addr == `SWDT_DATA_PORT);
  wire key_in  = bus.io_wdata == `SWDT_KEY_UNLOCK;
  wire exit_in = bus.io_wdata == `SWDT_KEY_EXIT;

  // register selection; activate and count registers against the latched logical device
  wire sel_ldev = index_r == `SWDT_REG_LDEV;
  wire sel_act  = (ldev_r == `SWDT_LDEV_ACT) && (index_r == `SWDT_REG_ACT);
  wire sel_tmo  = (ldev_r == `SWDT_LDEV_TMO) && (index_r == `SWDT_REG_TMO);

  // locked data writes never reach a register
  wire wr_ok   = dat_wr && cfg_r;
  wire tmo_wr  = wr_ok && sel_tmo;

  // ------------------------------------------------------------
  // counting conditions
  // ------------------------------------------------------------
  wire active   = act_r == `SWDT_ACT_ON;
  wire enabled  = tmo_r != `SWDT_RESET_VAL;
  wire counting = active && enabled && armed_r;
  wire sec_tick = counting && (pre_r == 32'(SEC_CYCLES - 1));
  wire expire   = sec_tick && (sec_r == 6'd0) && (min_r == 8'h00);

  // ------------------------------------------------------------
  // read data mux
  // ------------------------------------------------------------
  // unmapped registers read zero, locked reads read all ones
  wire swdt_byte_t rd_val =
      !cfg_r   ? `SWDT_RD_UNDEF :
      sel_ldev ? ldev_r :
      sel_act  ? act_r  :
      sel_tmo  ? tmo_r  :
                 `SWDT_RD_UNMAPPED;

  // ------------------------------------------------------------
  // configuration mode entry and exit
  // ------------------------------------------------------------
  // any other index write between the two keys breaks the pair
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cfg_r  <= 1'b0;
      key1_r <= 1'b0;
    end
    else if (ce && idx_wr)
    begin
      if (!cfg_r)
      begin
        cfg_r  <= key_in && key1_r;
        key1_r <= key_in && !key1_r;
      end
      else if (exit_in)
      begin
        cfg_r  <= 1'b0;
        key1_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // index latch
  // ------------------------------------------------------------
  // exit key is not stored so the index stays as last chosen
  always_ff @(posedge mclk)
  begin
    if (rst)
      index_r <= `SWDT_RESET_VAL;
    else if (ce && idx_wr && cfg_r && !exit_in)
      index_r <= bus.io_wdata;
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ldev_r <= `SWDT_RESET_VAL;
      act_r  <= `SWDT_RESET_VAL;
      tmo_r  <= `SWDT_RESET_VAL;
    end
    else if (ce && wr_ok)
    begin
      if (sel_ldev)
        ldev_r <= bus.io_wdata;
      else if (sel_act)
        act_r <= bus.io_wdata;
      else if (sel_tmo)
        tmo_r <= bus.io_wdata;
    end
  end

  // ------------------------------------------------------------
  // read answer
  // ------------------------------------------------------------
  // one cycle after the strobe; index-port reads answer the index while configuring, all ones when locked
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdata_r <= `SWDT_RESET_VAL;
      rack_r  <= 1'b0;
    end
    else if (ce)
    begin
      rack_r <= bus.io_rd;
      if (dat_rd)
        rdata_r <= rd_val;
      else if (bus.io_rd)
        rdata_r <= cfg_r ? index_r : `SWDT_RD_UNDEF;
    end
  end

  // ------------------------------------------------------------
  // second prescaler
  // ------------------------------------------------------------
  // restarts on each reload so the first step is a full 32 s
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pre_r <= 32'h0000_0000;
      run_r <= 1'b0;
    end
    else if (ce)
    begin
      run_r <= counting;
      if (tmo_wr || !counting || sec_tick)
        pre_r <= 32'h0000_0000;
      else
        pre_r <= pre_r + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // minute and second countdown
  // ------------------------------------------------------------
  // first step lasts 32 s, each later step one minute
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      min_r   <= `SWDT_RESET_VAL;
      sec_r   <= 6'd0;
      armed_r <= 1'b0;
    end
    else if (ce)
    begin
      if (tmo_wr)
      begin
        min_r   <= bus.io_wdata - 8'h01;
        sec_r   <= `SWDT_FIRST_SEC - 6'd1;
        armed_r <= 1'b1;
      end
      else if (expire)
        armed_r <= 1'b0;
      else if (sec_tick)
      begin
        if (sec_r != 6'd0)
          sec_r <= sec_r - 6'd1;
        else
        begin
          min_r <= min_r - 8'h01;
          sec_r <= `SWDT_MIN_SEC - 6'd1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // expiry action
  // ------------------------------------------------------------
  // reset is a fixed-width pulse; interrupt holds until a reload
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rst_cnt_r <= 6'd0;
      irq_r     <= 1'b0;
    end
    else if (ce)
    begin
      if (expire && !irq_sel)
        rst_cnt_r <= `SWDT_RST_CYC;
      else if (rst_cnt_r != 6'd0)
        rst_cnt_r <= rst_cnt_r - 6'd1;
      if (expire && irq_sel)
        irq_r <= 1'b1;
      else if (tmo_wr)
        irq_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign bus.io_rdata    = rdata_r;
  assign bus.io_rack     = rack_r;
  assign wdt_sys_reset   = rst_cnt_r != 6'd0;
  assign bus.wdt_reset   = wdt_sys_reset;
  assign wdt_irq         = irq_r;
  assign wdt_running     = run_r;  // low while inactive or disabled, one cycle late
endmodule

// ===== rtl/swdt_host.sv
// Purpose: controller that runs configuration sequences for software
// Assumes: avalon-mm slave, 32-bit data, byte addresses
// Notes:   one write or read of one device register per go command
`include "swdt_defines.svh"

module swdt_host (
  // clock, reset, enable
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          ce,
  // avalon-mm slave
  input  wire logic [4:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  // interrupt
  output logic               irq,
  // link to device
  swdt_if.host               bus
);
  import swdt_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  swdt_state_t st_r;
  swdt_byte_t  ldev_r;
  swdt_byte_t  regnum_r;
  swdt_byte_t  data_r;
  logic        rdmode_r;
  logic [1:0]  stat_r;
  logic [1:0]  mask_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  swdt_port_t  addr_r;
  swdt_byte_t  wdata_r;
  logic        wr_r;
  logic        rd_r;
  logic        wdrst_d_r;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // every access waits one cycle so read data come from a flop
  wire acc      = (avs_read || avs_write) && ce;
  wire take     = acc && ack_r;
  wire wr_take  = take && avs_write;
  wire busy     = st_r != SWDT_IDLE;
  wire go       = wr_take && (avs_address == `SWDT_A_CTRL) && !busy &&
                  avs_writedata[`SWDT_CTRL_GO];
  wire ev_done  = ce && (st_r == SWDT_EXIT);
  wire ev_wdrst = ce && bus.wdt_reset && !wdrst_d_r;
  wire clr_stat = wr_take && (avs_address == `SWDT_A_INT_STAT);
  wire [1:0] stat_nxt = (stat_r & ~(clr_stat ? avs_writedata[1:0] : 2'b00)) |
                        {ev_wdrst, ev_done};
  wire [31:0] rd_mux =
      (avs_address == `SWDT_A_LDEV)     ? {24'h000000, ldev_r}   :
      (avs_address == `SWDT_A_REGNUM)   ? {24'h000000, regnum_r} :
      (avs_address == `SWDT_A_DATA)     ? {24'h000000, data_r}   :
      (avs_address == `SWDT_A_CTRL)     ? {30'h0, rdmode_r, 1'b0} :
      (avs_address == `SWDT_A_STATUS)   ? {30'h0, bus.wdt_reset, busy} :
      (avs_address == `SWDT_A_INT_STAT) ? {30'h0, stat_r}        :
      (avs_address == `SWDT_A_INT_MASK) ? {30'h0, mask_r}        :
                                          32'h0000_0000;

  // ------------------------------------------------------------
  // avalon slave registers
  // ------------------------------------------------------------
  // data register is locked while a sequence runs
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ack_r <= 1'b0; rdata_r <= 32'h0000_0000; ldev_r <= 8'h00;
      regnum_r <= 8'h00; mask_r <= 2'b00; rdmode_r <= 1'b0;
    end
    else if (ce)
    begin
      ack_r <= acc && !ack_r;
      if (acc && !ack_r)
        rdata_r <= rd_mux;
      if (wr_take && !busy)
      begin
        if (avs_address == `SWDT_A_LDEV)
          ldev_r <= avs_writedata[7:0];
        else if (avs_address == `SWDT_A_REGNUM)
          regnum_r <= avs_writedata[7:0];
        else if (avs_address == `SWDT_A_CTRL)
          rdmode_r <= avs_writedata[`SWDT_CTRL_READ];
      end
      if (wr_take && avs_address == `SWDT_A_INT_MASK)
        mask_r <= avs_writedata[1:0];
    end
  end

  // ------------------------------------------------------------
  // interrupt status, set wins over clear
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stat_r    <= 2'b00;
      wdrst_d_r <= 1'b0;
    end
    else if (ce)
    begin
      stat_r    <= stat_nxt;
      wdrst_d_r <= bus.wdt_reset;
    end
  end

  // ------------------------------------------------------------
  // configuration sequence
  // ------------------------------------------------------------
  // unlock, select device, index, access, exit; one strobe a cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_r <= SWDT_IDLE; addr_r <= 16'h0000; wdata_r <= 8'h00;
      wr_r <= 1'b0; rd_r <= 1'b0; data_r <= 8'h00;
    end
    else if (ce)
    begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      if (wr_take && !busy && avs_address == `SWDT_A_DATA)
        data_r <= avs_writedata[7:0];
      case (st_r)
        SWDT_IDLE:  if (go) st_r <= SWDT_KEY1;
        SWDT_KEY1:
        begin
          addr_r <= `SWDT_INDEX_PORT; wdata_r <= `SWDT_KEY_UNLOCK; wr_r <= 1'b1;
          st_r <= SWDT_KEY2;
        end
        SWDT_KEY2:
        begin
          wr_r <= 1'b1; st_r <= SWDT_SELI;
        end
        SWDT_SELI:
        begin
          wdata_r <= `SWDT_REG_LDEV; wr_r <= 1'b1; st_r <= SWDT_SELD;
        end
        SWDT_SELD:
        begin
          addr_r <= `SWDT_DATA_PORT; wdata_r <= ldev_r; wr_r <= 1'b1;
          st_r <= SWDT_IDX;
        end
        SWDT_IDX:
        begin
          addr_r <= `SWDT_INDEX_PORT; wdata_r <= regnum_r; wr_r <= 1'b1;
          st_r <= SWDT_DAT;
        end
        SWDT_DAT:
        begin
          addr_r <= `SWDT_DATA_PORT; wdata_r <= data_r;
          wr_r <= !rdmode_r; rd_r <= rdmode_r;
          st_r <= rdmode_r ? SWDT_RWAIT : SWDT_EXIT;
        end
        SWDT_RWAIT:
          if (bus.io_rack)
          begin
            data_r <= bus.io_rdata; st_r <= SWDT_EXIT;
          end
        SWDT_EXIT:
        begin
          addr_r <= `SWDT_INDEX_PORT; wdata_r <= `SWDT_KEY_EXIT; wr_r <= 1'b1;
          st_r <= SWDT_IDLE;
        end
        default:    st_r <= SWDT_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !(ack_r && ce);
  assign avs_readdata    = rdata_r;
  assign irq             = |(stat_r & mask_r);
  assign bus.io_addr     = addr_r;
  assign bus.io_wdata    = wdata_r;
  assign bus.io_wr       = wr_r;
  assign bus.io_rd       = rd_r;
endmodule

// ===== rtl/swdt_if.sv
// Purpose: i/o port cycle link between controller and watchdog device
// Assumes: both ends on mclk
// Notes:   wr and rd are one-cycle strobes
interface swdt_if;
  import swdt_pkg::*;
  swdt_port_t io_addr;
  swdt_byte_t io_wdata;
  logic       io_wr;
  logic       io_rd;
  swdt_byte_t io_rdata;
  logic       io_rack;
  logic       wdt_reset;

  modport dev  (input io_addr, io_wdata, io_wr, io_rd,
                output io_rdata, io_rack, wdt_reset);
  modport host (output io_addr, io_wdata, io_wr, io_rd,
                input io_rdata, io_rack, wdt_reset);
endinterface

// ===== rtl/swdt_pkg.sv
// Purpose: types shared by both ends
// Assumes: nothing
// Notes:   numbers live in swdt_defines.svh
package swdt_pkg;
  typedef logic [7:0]  swdt_byte_t;
  typedef logic [15:0] swdt_port_t;

  // controller sequence states
  typedef enum logic [3:0] {
    SWDT_IDLE  = 4'b0000,
    SWDT_KEY1  = 4'b0001,
    SWDT_KEY2  = 4'b0010,
    SWDT_SELI  = 4'b0011,
    SWDT_SELD  = 4'b0100,
    SWDT_IDX   = 4'b0101,
    SWDT_DAT   = 4'b0110,
    SWDT_RWAIT = 4'b0111,
    SWDT_EXIT  = 4'b1000
  } swdt_state_t;
endpackage

// ===== test/superio_watchdog_timer_tb.sv
// Purpose: drives the controller over avalon and checks the watchdog
// Assumes: prescaler shortened to 10 cycles per second
// Notes:   expiry is timed from the last data-port write on the link
`include "swdt_defines.svh"

module superio_watchdog_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import swdt_pkg::*;
  localparam int SEC = 10;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        irq_sel = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        sys_rst;
  logic        wdt_irq;
  logic        running;
  logic [31:0] q;
  int          errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          dw_cyc = 0;

  swdt_if link ();
  swdt_host swdt_host_i (.mclk(mclk), .rst(rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .bus(link));
  swdt_dev #(.SEC_CYCLES(SEC)) swdt_dev_i (.mclk(mclk), .rst(rst), .ce(ce), .bus(link),
    .irq_sel(irq_sel), .wdt_sys_reset(sys_rst), .wdt_irq(wdt_irq), .wdt_running(running));
  swdt_chk swdt_chk_i (.mclk(mclk), .rst(rst), .io_addr(link.io_addr),
    .io_wdata(link.io_wdata), .io_wr(link.io_wr), .io_rd(link.io_rd),
    .io_rdata(link.io_rdata), .io_rack(link.io_rack), .wdt_reset(link.wdt_reset));

  // clock and a cycle stamp of the last data-port write
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (link.io_wr === 1'b1 && link.io_addr === `SWDT_DATA_PORT)
      dw_cyc <= cyc;
  end

  task automatic end_of_test;
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // one avalon cycle; an extra edge keeps back-to-back strobes apart
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50)
    begin
      errors++;
      end_of_test;
    end
    @(posedge mclk);
  endtask

  // one configuration sequence run by the controller
  task automatic cfg(input logic [7:0] ld, input logic [7:0] rg, input logic [7:0] v,
                     input logic rd, output logic [31:0] r);
    int n;
    bus(1'b1, `SWDT_A_LDEV, {24'h0, ld}, r);
    bus(1'b1, `SWDT_A_REGNUM, {24'h0, rg}, r);
    bus(1'b1, `SWDT_A_DATA, {24'h0, v}, r);
    bus(1'b1, `SWDT_A_CTRL, {30'h0, rd, 1'b1}, r);
    n = 0;
    do
    begin
      bus(1'b0, `SWDT_A_STATUS, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 40);
    if (n >= 40)
    begin
      errors++;
      end_of_test;
    end
    bus(1'b0, `SWDT_A_DATA, 32'h0, r);
  endtask

  // arm with count n, time the expiry on the chosen output
  task automatic tmo(input logic [7:0] n, input logic sel);
    int k;
    int d;
    logic [31:0] r;
    irq_sel <= sel;
    cfg(8'h08, `SWDT_REG_TMO, n, 1'b0, r);
    k = 0;
    while ((sel ? wdt_irq : sys_rst) !== 1'b1 && k < 3000)
    begin
      @(posedge mclk);
      k++;
    end
    if (k >= 3000)
    begin
      errors++;
      end_of_test;
    end
    d = cyc - dw_cyc - ((n - 1) * 60 + 32) * SEC;
    chk({31'h0, d >= -2 && d <= 3}, 32'h1);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    bus(1'b0, 5'h1C, 32'h0, q); chk(q, 32'h0);
    bus(1'b0, `SWDT_A_INT_MASK, 32'h0, q); chk(q, 32'h0);
    cfg(8'h07, `SWDT_REG_ACT, 8'h00, 1'b1, q); chk(q, 32'h0);
    cfg(8'h07, `SWDT_REG_ACT, `SWDT_ACT_ON, 1'b0, q);
    cfg(8'h07, `SWDT_REG_ACT, 8'h00, 1'b1, q); chk(q, 32'h1);
    cfg(8'h07, `SWDT_REG_TMO, 8'h00, 1'b1, q); chk(q, 32'h0);
    cfg(8'h08, `SWDT_REG_TMO, 8'h00, 1'b0, q); chk(running, 32'h0);
    cfg(8'h08, `SWDT_REG_TMO, 8'h05, 1'b0, q); chk(running, 32'h1);
    cfg(8'h08, `SWDT_REG_TMO, 8'h00, 1'b1, q); chk(q, 32'h5);
    cfg(8'h07, `SWDT_REG_ACT, 8'h00, 1'b0, q); chk(running, 32'h0);
    cfg(8'h07, `SWDT_REG_ACT, `SWDT_ACT_ON, 1'b0, q);
    // a second write partway through must restart the count
    cfg(8'h08, `SWDT_REG_TMO, 8'h01, 1'b0, q);
    repeat (200) @(posedge mclk);
    tmo(8'h01, 1'b0);
    repeat (40) @(posedge mclk);
    chk(sys_rst, 32'h0);
    bus(1'b0, `SWDT_A_INT_STAT, 32'h0, q); chk(q & 32'h3, 32'h3);
    chk(irq, 32'h0);
    bus(1'b1, `SWDT_A_INT_MASK, 32'h2, q); chk(irq, 32'h1);
    bus(1'b1, `SWDT_A_INT_STAT, 32'h3, q); chk(irq, 32'h0);
    tmo(8'h02, 1'b1);
    chk(sys_rst, 32'h0);
    cfg(8'h08, `SWDT_REG_TMO, 8'h00, 1'b0, q); chk(wdt_irq, 32'h0);
    end_of_test;
  end
endmodule

// ===== test/swdt_chk.sv
// Purpose: concurrent checks on the configuration link
// Assumes: one mclk domain, rst synchronous active high
// Notes:   instantiated beside the link, no bind
`include "swdt_defines.svh"

module swdt_chk (
  // clock and reset
  input wire logic               mclk,
  input wire logic               rst,
  // link signals
  input wire swdt_pkg::swdt_port_t io_addr,
  input wire swdt_pkg::swdt_byte_t io_wdata,
  input wire logic               io_wr,
  input wire logic               io_rd,
  input wire swdt_pkg::swdt_byte_t io_rdata,
  input wire logic               io_rack,
  input wire logic               wdt_reset
);
  import swdt_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // sequence shape on the link
  // ------------------------------------------------------------
  // an exit write after a read also starts a burst, so it is kept out of the antecedent
  key_pair_a: assert property (
    $rose(io_wr) && io_wdata != `SWDT_KEY_EXIT |-> io_addr == `SWDT_INDEX_PORT
    && io_wdata == `SWDT_KEY_UNLOCK ##1 io_wr && io_wdata == `SWDT_KEY_UNLOCK)
    else $error("unlock keys not sent back to back");
  ldev_sel_a: assert property (
    $rose(io_wr) && io_wdata != `SWDT_KEY_EXIT |-> ##2 io_wr
    && io_addr == `SWDT_INDEX_PORT && io_wdata == `SWDT_REG_LDEV
    ##1 io_wr && io_addr == `SWDT_DATA_PORT)
    else $error("device select step missing");
  reg_access_a: assert property (
    $rose(io_wr) && io_wdata != `SWDT_KEY_EXIT |-> ##4 io_wr
    && io_addr == `SWDT_INDEX_PORT ##1 (io_wr || io_rd) && io_addr == `SWDT_DATA_PORT)
    else $error("register index not followed by data access");
  port_decode_a: assert property (
    (io_wr || io_rd) |-> io_addr == `SWDT_INDEX_PORT || io_addr == `SWDT_DATA_PORT)
    else $error("strobe to a port outside the pair");
  one_strobe_a: assert property (!(io_wr && io_rd))
    else $error("read and write strobes together");

  // ------------------------------------------------------------
  // read answer and exit
  // ------------------------------------------------------------
  rd_answer_a: assert property (io_rd |=> io_rack && !io_rd)
    else $error("read not answered next cycle");
  rack_cause_a: assert property (io_rack |-> $past(io_rd))
    else $error("answer without a read");
  exit_after_rd_a: assert property (
    io_rack |-> ##[1:2] io_wr && io_addr == `SWDT_INDEX_PORT && io_wdata == `SWDT_KEY_EXIT)
    else $error("no exit key after read");
  exit_last_a: assert property (
    io_wr && io_wdata == `SWDT_KEY_EXIT && io_addr == `SWDT_INDEX_PORT |=> !io_wr && !io_rd)
    else $error("access after exit key");

  // ------------------------------------------------------------
  // system reset pulse
  // ------------------------------------------------------------
  rst_width_a: assert property ($fell(wdt_reset) |-> $past(wdt_reset, 32))
    else $error("system reset pulse too short");
endmodule
